// >>> rtl/fbgp_port.sv
// Purpose : Four-pin general-purpose port bank with edge events
// Assumes : Pins synchronous to clk_in; Avalon-MM slave, byte addresses
// Notes   : reset_in is the bank master reset; host reset spares registers
`timescale 1ns/1ps
`include "fbgp_defs.svh"

module fbgp_port #(
    parameter int PIN_COUNT = 4
) (
    // Clock, resets and enable
    input  wire logic                   clk_in,
    input  wire logic                   reset_in,
    input  wire logic                   host_bus_reset_n_in,
    input  wire logic                   ce_in,
    // Avalon-MM slave
    input  wire logic [`FBGP_ADDR_W-1:0] avs_address_in,
    input  wire logic                   avs_read_in,
    input  wire logic                   avs_write_in,
    input  wire logic [31:0]            avs_writedata_in,
    input  wire logic [3:0]             avs_byteenable_in,
    output logic [31:0]                 avs_readdata_out,
    output logic                        avs_waitrequest_out,
    // Port pins
    input  wire logic [PIN_COUNT-1:0]   port_pins_in,
    output logic [PIN_COUNT-1:0]        port_pins_out,
    output logic [PIN_COUNT-1:0]        port_pins_oe_n_out,
    // Interrupt
    output logic                        irq_out
);

    // ------------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------------
    fbgp_pkg::fbgp_req_t   req;
    fbgp_pkg::fbgp_state_t state_reg;
    fbgp_pkg::fbgp_state_t state_next;

    // Register, pin and event state
    logic [PIN_COUNT-1:0] direction_reg;
    logic [PIN_COUNT-1:0] data_reg;
    logic [PIN_COUNT-1:0] polarity_reg;
    logic [PIN_COUNT-1:0] edge_status_reg;
    logic [PIN_COUNT-1:0] int_status_reg;
    logic [PIN_COUNT-1:0] int_enable_reg;
    logic [PIN_COUNT-1:0] pin_prev_reg;
    logic [PIN_COUNT-1:0] edge_seen;
    logic [PIN_COUNT-1:0] data_view;
    logic [PIN_COUNT-1:0] rd_clear_reg;
    logic [31:0]          rd_word;
    logic [31:0]          readdata_reg;
    logic [7:0]           req_idx;
    logic                 commit;
    logic                 wr_commit;
    logic                 low_lane;
    logic                 arm_reg;

    // Per-register strobes, decoded once from the committed access
    logic                 wr_direction;
    logic                 wr_data;
    logic                 wr_polarity;
    logic                 wr_int_enable;
    logic                 wr_int_clear;
    logic                 rd_edge_status;

    // ------------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------------

    // Decode a register index out of a byte address
    function automatic logic [7:0] fbgp_index(input logic [`FBGP_ADDR_W-1:0] addr);
        fbgp_index = addr[`FBGP_IDX_MSB:`FBGP_IDX_LSB];
    endfunction

    // True when the decoded index names the given register
    function automatic logic fbgp_hit(input logic [7:0] idx, input logic [7:0] target);
        fbgp_hit = (idx == target);
    endfunction

    // Place a narrow field in the low bits, upper bits read as zero
    function automatic logic [31:0] fbgp_widen(input logic [PIN_COUNT-1:0] v);
        fbgp_widen = `FBGP_RD_ZERO;
        fbgp_widen[PIN_COUNT-1:0] = v;
    endfunction

    // ------------------------------------------------------------------
    // Bus request and handshake
    // ------------------------------------------------------------------

    // Gather the request into one carrier
    assign req.read      = avs_read_in;
    assign req.write     = avs_write_in;
    assign req.address   = avs_address_in;
    assign req.writedata = avs_writedata_in;

    assign req_idx  = fbgp_index(req.address);
    assign low_lane = avs_byteenable_in[0];

    // The access completes on the edge where the slave sits in ACK
    assign commit    = ce_in && (state_reg == fbgp_pkg::FBGP_ACK);
    assign wr_commit = commit && req.write && low_lane;

    // Waitrequest held high until the one-cycle answer is ready
    assign avs_waitrequest_out = !commit;
    assign avs_readdata_out    = readdata_reg;

    // Next state: one wait cycle, then answer
    always_comb
    begin
        state_next = state_reg;
        case (state_reg)
            fbgp_pkg::FBGP_IDLE:
            begin
                if (req.read || req.write)
                    state_next = fbgp_pkg::FBGP_ACK;
            end
            fbgp_pkg::FBGP_ACK:
            begin
                state_next = fbgp_pkg::FBGP_IDLE;
            end
            default:
            begin
                state_next = fbgp_pkg::FBGP_IDLE;
            end
        endcase
    end

    // Slave state; only bus-facing logic follows the host reset
    always_ff @(posedge clk_in or posedge reset_in)
    begin
        if (reset_in)
            state_reg <= fbgp_pkg::FBGP_IDLE;
        else if (!host_bus_reset_n_in)
            state_reg <= fbgp_pkg::FBGP_IDLE;
        else if (ce_in)
            state_reg <= state_next;
    end

    // ------------------------------------------------------------------
    // Register strobes
    // ------------------------------------------------------------------

    // One strobe per register; each is live only on the committing edge
    assign wr_direction   = wr_commit && fbgp_hit(req_idx, `FBGP_IDX_DIRECTION);
    assign wr_data        = wr_commit && fbgp_hit(req_idx, `FBGP_IDX_DATA);
    assign wr_polarity    = wr_commit && fbgp_hit(req_idx, `FBGP_IDX_POLARITY);
    assign wr_int_enable  = wr_commit && fbgp_hit(req_idx, `FBGP_IDX_INT_ENABLE);
    assign wr_int_clear   = wr_commit && fbgp_hit(req_idx, `FBGP_IDX_INT_CLEAR);
    // Read-clear only when the read really completes, never on a stall
    assign rd_edge_status = commit && req.read
                         && fbgp_hit(req_idx, `FBGP_IDX_EDGE_STATUS);

    // ------------------------------------------------------------------
    // Pin view and drive
    // ------------------------------------------------------------------

    // Value seen through the data register, per pin direction
    generate
        for (genvar i = 0; i < PIN_COUNT; i++)
        begin : g_view
            always_comb
            begin
                if (direction_reg[i])
                    data_view[i] = port_pins_in[i] ^ polarity_reg[i];
                else
                    data_view[i] = data_reg[i];
            end
        end
    endgenerate

    // Pin drive registered; input pins release their driver
    always_ff @(posedge clk_in or posedge reset_in)
    begin
        if (reset_in)
        begin
            port_pins_out      <= `FBGP_RST_ZERO;
            port_pins_oe_n_out <= `FBGP_RST_DIRECTION;
        end
        else if (ce_in)
        begin
            port_pins_out      <= data_reg ^ polarity_reg;
            port_pins_oe_n_out <= direction_reg;
        end
    end

    // ------------------------------------------------------------------
    // Configuration registers
    // ------------------------------------------------------------------

    // Direction register; reserved upper bits are not stored
    always_ff @(posedge clk_in or posedge reset_in)
    begin
        if (reset_in)
            direction_reg <= `FBGP_RST_DIRECTION;
        else if (wr_direction)
            direction_reg <= req.writedata[PIN_COUNT-1:0];
    end

    // Data register; bits of input pins keep their value on write
    always_ff @(posedge clk_in or posedge reset_in)
    begin
        if (reset_in)
            data_reg <= `FBGP_RST_ZERO;
        else if (wr_data)
            data_reg <= (data_reg & direction_reg)
                      | (req.writedata[PIN_COUNT-1:0] & ~direction_reg);
    end

    // Polarity register
    always_ff @(posedge clk_in or posedge reset_in)
    begin
        if (reset_in)
            polarity_reg <= `FBGP_RST_ZERO;
        else if (wr_polarity)
            polarity_reg <= req.writedata[PIN_COUNT-1:0];
    end

    // Interrupt enable register
    always_ff @(posedge clk_in or posedge reset_in)
    begin
        if (reset_in)
            int_enable_reg <= `FBGP_RST_ZERO;
        else if (wr_int_enable)
            int_enable_reg <= req.writedata[PIN_COUNT-1:0];
    end

    // ------------------------------------------------------------------
    // Edge events
    // ------------------------------------------------------------------

    // Previous pin level; both edges count as active
    always_ff @(posedge clk_in or posedge reset_in)
    begin
        if (reset_in)
            pin_prev_reg <= `FBGP_RST_ZERO;
        else if (ce_in)
            pin_prev_reg <= port_pins_in;
    end

    // Armed after the first enabled sample: a pin that idles high at
    // reset release would otherwise look like an edge against the reset
    // value of the previous-level register
    always_ff @(posedge clk_in or posedge reset_in)
    begin
        if (reset_in)
            arm_reg <= 1'b0;
        else if (ce_in)
            arm_reg <= 1'b1;
    end

    // Change between consecutive enabled samples, any pin direction
    assign edge_seen = (ce_in && arm_reg) ? (port_pins_in ^ pin_prev_reg)
                                          : `FBGP_RST_ZERO;

    // Edge status: set wins over the read-clear of the same cycle
    always_ff @(posedge clk_in or posedge reset_in)
    begin
        if (reset_in)
            edge_status_reg <= `FBGP_RST_ZERO;
        else if (rd_edge_status)
            edge_status_reg <= (edge_status_reg & ~rd_clear_reg) | edge_seen;
        else
            edge_status_reg <= edge_status_reg | edge_seen;
    end

    // Interrupt status: sticky, cleared by writing ones to the clear index
    always_ff @(posedge clk_in or posedge reset_in)
    begin
        if (reset_in)
            int_status_reg <= `FBGP_RST_ZERO;
        else if (wr_int_clear)
            int_status_reg <= (int_status_reg & ~req.writedata[PIN_COUNT-1:0])
                            | edge_seen;
        else
            int_status_reg <= int_status_reg | edge_seen;
    end

    // Level interrupt while any enabled status bit is set; registered,
    // so it trails a status change by one cycle
    always_ff @(posedge clk_in or posedge reset_in)
    begin
        if (reset_in)
            irq_out <= 1'b0;
        else if (ce_in)
            irq_out <= |(int_status_reg & int_enable_reg);
    end

    // ------------------------------------------------------------------
    // Read path
    // ------------------------------------------------------------------

    // Read mux; unmapped indices and write-only clear read zero
    always_comb
    begin
        rd_word = `FBGP_RD_ZERO;
        case (req_idx)
            `FBGP_IDX_DIRECTION:   rd_word = fbgp_widen(direction_reg);
            `FBGP_IDX_DATA:        rd_word = fbgp_widen(data_view);
            `FBGP_IDX_POLARITY:    rd_word = fbgp_widen(polarity_reg);
            `FBGP_IDX_EDGE_STATUS: rd_word = fbgp_widen(edge_status_reg);
            `FBGP_IDX_INT_STATUS:  rd_word = fbgp_widen(int_status_reg);
            `FBGP_IDX_INT_ENABLE:  rd_word = fbgp_widen(int_enable_reg);
            default:               rd_word = `FBGP_RD_ZERO;
        endcase
    end

    // Read data captured in the wait cycle, stands through the answer
    always_ff @(posedge clk_in or posedge reset_in)
    begin
        if (reset_in)
        begin
            readdata_reg <= `FBGP_RD_ZERO;
            rd_clear_reg <= `FBGP_RST_ZERO;
        end
        else if (!host_bus_reset_n_in)
        begin
            readdata_reg <= `FBGP_RD_ZERO;
            rd_clear_reg <= `FBGP_RST_ZERO;
        end
        else if (ce_in && state_reg == fbgp_pkg::FBGP_IDLE && req.read)
        begin
            readdata_reg <= rd_word;
            // Only bits returned to software are cleared later
            rd_clear_reg <= rd_word[PIN_COUNT-1:0];
        end
    end

    // Byte lanes above the first carry no register bits
    logic unused_lanes;
    assign unused_lanes = |avs_byteenable_in[3:`FBGP_LANE_MSB];

endmodule

// >>> rtl/fbgp_defs.svh
// Purpose : Offsets, reset values and field positions of the port bank
// Assumes : Included by bare name from the design file
// Notes   : Offsets are register indices; byte address is four times index
`ifndef FBGP_DEFS_SVH
`define FBGP_DEFS_SVH

// ----------------------------------------------------------------------
// Register indices
// ----------------------------------------------------------------------
`define FBGP_IDX_DIRECTION   8'hE0
`define FBGP_IDX_DATA        8'hE1
`define FBGP_IDX_POLARITY    8'hE2
`define FBGP_IDX_EDGE_STATUS 8'hE3
`define FBGP_IDX_INT_STATUS  8'hF0
`define FBGP_IDX_INT_ENABLE  8'hF1
`define FBGP_IDX_INT_CLEAR   8'hF2

// ----------------------------------------------------------------------
// Address layout and reset values
// ----------------------------------------------------------------------
`define FBGP_ADDR_W          10
`define FBGP_IDX_LSB         2
`define FBGP_IDX_MSB         9
`define FBGP_LANE_MSB        1
`define FBGP_RST_DIRECTION   4'hF
`define FBGP_RST_ZERO        4'h0
`define FBGP_RD_ZERO         32'h0000_0000

`endif

// >>> rtl/fbgp_pkg.sv
// Purpose : Types shared by the port bank
// Assumes : Used with package-qualified names only
// Notes   : Bus request travels as one packed struct
package fbgp_pkg;

    // ------------------------------------------------------------------
    // Bus request carrier
    // ------------------------------------------------------------------
    typedef struct packed {
        logic        read;
        logic        write;
        logic [9:0]  address;
        logic [31:0] writedata;
    } fbgp_req_t;

    // ------------------------------------------------------------------
    // Bus slave states, one-hot
    // ------------------------------------------------------------------
    typedef enum logic [1:0] {
        FBGP_IDLE = 2'b01,
        FBGP_ACK  = 2'b10
    } fbgp_state_t;

endpackage

// >>> test/fbgp_port_monitor.sv
// Purpose: Port and bus checks for the port bank
// Assumes: Sees only the top-level ports
// Notes  : Polarity is shadowed from completed writes
`timescale 1ns/1ps
`include "fbgp_defs.svh"
module fbgp_port_monitor #(
    parameter int PIN_COUNT = 4
) (
    // Clock and resets
    input wire logic                    clk_in,
    input wire logic                    reset_in,
    input wire logic                    host_bus_reset_n_in,
    input wire logic                    ce_in,
    // Bus
    input wire logic [`FBGP_ADDR_W-1:0] avs_address_in,
    input wire logic                    avs_read_in,
    input wire logic                    avs_write_in,
    input wire logic [31:0]             avs_writedata_in,
    input wire logic [3:0]              avs_byteenable_in,
    input wire logic [31:0]             avs_readdata_out,
    input wire logic                    avs_waitrequest_out,
    // Pins and interrupt
    input wire logic [PIN_COUNT-1:0]    port_pins_in,
    input wire logic [PIN_COUNT-1:0]    port_pins_out,
    input wire logic [PIN_COUNT-1:0]    port_pins_oe_n_out,
    input wire logic                    irq_out
);
    // ------------------------------------------------------------
    // Completed accesses
    // ------------------------------------------------------------
    wire [7:0] idx = avs_address_in[`FBGP_IDX_MSB:`FBGP_IDX_LSB];
    wire req = avs_read_in || avs_write_in;
    wire rd_ok = avs_read_in && !avs_waitrequest_out;
    wire wr_ok = avs_write_in && !avs_waitrequest_out && avs_byteenable_in[0];
    logic [PIN_COUNT-1:0] pol_reg;
    // Shadow polarity so pin checks need no hierarchy access
    always_ff @(posedge clk_in or posedge reset_in)
    begin
        if (reset_in)
            pol_reg <= '0;
        else if (wr_ok && idx == `FBGP_IDX_POLARITY)
            pol_reg <= avs_writedata_in[PIN_COUNT-1:0];
    end
    default clocking cb @(posedge clk_in);
    endclocking
    default disable iff (reset_in);
    sequence s_taken;
        $rose(req) && avs_waitrequest_out && ce_in;
    endsequence
    sequence s_answer;
        !avs_waitrequest_out ##1 avs_waitrequest_out;
    endsequence
    property p_one_wait;
        s_taken |=> s_answer;
    endproperty
    a_one_wait: assert property (p_one_wait) else $error("bus answer out of place");
    property p_oe_dir;
        wr_ok && idx == `FBGP_IDX_DIRECTION
            |-> ##2 port_pins_oe_n_out == $past(avs_writedata_in[PIN_COUNT-1:0], 2);
    endproperty
    a_oe_dir: assert property (p_oe_dir) else $error("enable differs");
    property p_rst_val;
        $past(reset_in) |-> port_pins_oe_n_out == '1 && port_pins_out == '0;
    endproperty
    a_rst_val: assert property (p_rst_val) else $error("bad pins at reset");
    property p_host_keep;
        !host_bus_reset_n_in |=> $stable(port_pins_oe_n_out) && avs_readdata_out == '0;
    endproperty
    a_host_keep: assert property (p_host_keep) else $error("host reset leak");
    property p_drive;
        wr_ok && idx == `FBGP_IDX_DATA && port_pins_oe_n_out == '0
            |-> ##2 port_pins_out == ($past(avs_writedata_in[PIN_COUNT-1:0], 2) ^ pol_reg);
    endproperty
    a_drive: assert property (p_drive) else $error("drive differs");
    property p_in_drop;
        wr_ok && idx == `FBGP_IDX_DATA && port_pins_oe_n_out == '1 |-> ##2 $stable(port_pins_out);
    endproperty
    a_in_drop: assert property (p_in_drop) else $error("input write taken");
    property p_in_read;
        rd_ok && idx == `FBGP_IDX_DATA && port_pins_in == $past(port_pins_in, 3)
            |-> ((avs_readdata_out[PIN_COUNT-1:0] ^ port_pins_in ^ pol_reg)
                & port_pins_oe_n_out) == '0;
    endproperty
    a_in_read: assert property (p_in_read) else $error("pin read differs");
    property p_hi_zero;
        rd_ok |-> avs_readdata_out[31:4] == 28'h0000000;
    endproperty
    a_hi_zero: assert property (p_hi_zero) else $error("reserved bits set");
    property p_ce_stall;
        !ce_in |-> avs_waitrequest_out;
    endproperty
    a_ce_stall: assert property (p_ce_stall) else $error("answer while enable low");
endmodule
bind fbgp_port fbgp_port_monitor #(.PIN_COUNT(PIN_COUNT)) u_fbgp_port_monitor (
    .clk_in(clk_in), .reset_in(reset_in), .host_bus_reset_n_in(host_bus_reset_n_in),
    .ce_in(ce_in), .avs_address_in(avs_address_in), .avs_read_in(avs_read_in),
    .avs_write_in(avs_write_in), .avs_writedata_in(avs_writedata_in),
    .avs_byteenable_in(avs_byteenable_in), .avs_readdata_out(avs_readdata_out),
    .avs_waitrequest_out(avs_waitrequest_out), .port_pins_in(port_pins_in),
    .port_pins_out(port_pins_out), .port_pins_oe_n_out(port_pins_oe_n_out), .irq_out(irq_out));

// >>> test/fbgp_board_model.sv
// Purpose: Board side of the port pins
// Assumes: A board source drives every pin the bank releases
// Notes  : A driven pin reads back the bank's own level
`timescale 1ns/1ps
module fbgp_board_model #(
    parameter int PIN_COUNT = 4
) (
    // Bank side
    input  wire logic [PIN_COUNT-1:0] drive_in,
    input  wire logic [PIN_COUNT-1:0] oe_n_in,
    // Board source
    input  wire logic [PIN_COUNT-1:0] ext_in,
    output logic [PIN_COUNT-1:0]      level_out
);
    // Bank wins where it drives, so the source never fights it
    always_comb
    begin
        for (int i = 0; i < PIN_COUNT; i++)
            level_out[i] = oe_n_in[i] ? ext_in[i] : drive_in[i];
    end
endmodule

// >>> test/tb_fbgp_port.sv
// Purpose: Self-checking bench for the port bank
// Assumes: One bus request at a time
// Notes  : Driver queues read results, a watcher checks them
`timescale 1ns/1ps
`include "fbgp_defs.svh"
module tb_fbgp_port;
    // ------------------------------------------------------------
    // Signals and helpers
    // ------------------------------------------------------------
    localparam logic [9:0] A_DIR = {`FBGP_IDX_DIRECTION, 2'b00};
    localparam logic [9:0] A_DAT = {`FBGP_IDX_DATA, 2'b00};
    localparam logic [9:0] A_POL = {`FBGP_IDX_POLARITY, 2'b00};
    localparam logic [9:0] A_EVT = {`FBGP_IDX_EDGE_STATUS, 2'b00};
    localparam logic [9:0] A_IEN = {`FBGP_IDX_INT_ENABLE, 2'b00};
    localparam logic [9:0] A_ICL = {`FBGP_IDX_INT_CLEAR, 2'b00};
    localparam logic [9:0] A_IST = {`FBGP_IDX_INT_STATUS, 2'b00};
    logic clk_in = 1'b0;
    logic reset_in = 1'b1;
    logic host_rst_n = 1'b1;
    logic ce = 1'b1;
    fbgp_pkg::fbgp_req_t req = '0;
    logic [3:0] be = 4'hF;
    logic [3:0] ext = 4'h0;
    logic [31:0] rdata;
    logic wait_s;
    logic irq;
    logic [3:0] pins_in;
    logic [3:0] pins_out;
    logic [3:0] oe_n;
    logic [63:0] exp_q[$];
    logic [63:0] ent;
    logic [31:0] rnd = 32'h0000_0034;
    logic [3:0] d;
    logic [3:0] p;
    logic [3:0] t;
    int failures = 0;
    int tests_run = 0;
    int cyc = 0;
    always #10 clk_in = ~clk_in;
    fbgp_port u_fbgp_port (.clk_in(clk_in), .reset_in(reset_in),
        .host_bus_reset_n_in(host_rst_n), .ce_in(ce), .avs_address_in(req.address),
        .avs_read_in(req.read), .avs_write_in(req.write), .avs_writedata_in(req.writedata),
        .avs_byteenable_in(be), .avs_readdata_out(rdata), .avs_waitrequest_out(wait_s),
        .port_pins_in(pins_in), .port_pins_out(pins_out), .port_pins_oe_n_out(oe_n),
        .irq_out(irq));
    fbgp_board_model u_fbgp_board_model (.drive_in(pins_out), .oe_n_in(oe_n),
        .ext_in(ext), .level_out(pins_in));
    function automatic logic [3:0] xs();
        rnd ^= rnd << 13;
        rnd ^= rnd >> 17;
        rnd ^= rnd << 5;
        return rnd[3:0];
    endfunction
    task automatic chk_rd(input logic [31:0] e, input logic [31:0] g);
        tests_run++;
        if (g !== e)
        begin
            failures++;
            $display("ERROR %0t exp %h got %h", $time, e, g);
        end
    endtask
    task automatic chk_pin(input logic [3:0] e, input logic [3:0] g);
        chk_rd({28'h0, e}, {28'h0, g});
    endtask
    task automatic give_verdict();
        $display("comparisons %0d mismatches %0d", tests_run, failures);
        if (failures == 0 && tests_run > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask
    // Hold the request until waitrequest is sampled low, then release
    task automatic bus(input logic w, input logic [9:0] a, input logic [31:0] v,
                       input logic [3:0] b);
        int n;
        n = 0;
        @(posedge clk_in);
        req <= '{!w, w, a, v};
        be <= b;
        do
        begin
            @(posedge clk_in);
            n++;
        end
        while (wait_s !== 1'b0 && n < 40);
        if (wait_s !== 1'b0)
            failures++;
        req <= '0;
    endtask
    task automatic wr(input logic [9:0] a, input logic [31:0] v);
        bus(1'b1, a, v, 4'hF);
    endtask
    task automatic rd(input logic [9:0] a, input logic [31:0] e, input logic [31:0] m);
        exp_q.push_back({m, e});
        bus(1'b0, a, 32'h0, 4'hF);
    endtask
    // Watcher: read data stand at the edge where waitrequest is low
    always @(posedge clk_in)
    begin
        cyc++;
        if (req.read && wait_s === 1'b0 && exp_q.size() > 0)
        begin
            ent = exp_q.pop_front();
            chk_rd(ent[31:0], rdata & ent[63:32]);
        end
        if (cyc == 5000)
        begin
            failures++;
            give_verdict();
        end
    end
    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    initial
    begin
        repeat (20) @(posedge clk_in);
        reset_in <= 1'b0;
        rd(A_DIR, 32'h0F, '1);
        rd(A_POL, 32'h00, '1);
        rd(A_EVT, 32'h00, '1);
        rd(10'h000, 32'h00, '1);
        wr(A_EVT, 32'h0F);
        rd(A_EVT, 32'h00, '1);
        wr(A_DIR, 32'hA5);
        rd(A_DIR, 32'h05, '1);
        chk_pin(4'h5, oe_n);
        wr(A_DIR, 32'h00);
        d = xs();
        wr(A_DAT, {28'h0, d});
        rd(A_DAT, {28'h0, d}, '1);
        chk_pin(d, pins_out);
        bus(1'b1, A_DAT, {28'h0, ~d}, 4'hE);
        p = xs();
        wr(A_POL, {28'h0, p});
        rd(A_DAT, {28'h0, d}, '1);
        chk_pin(d ^ p, pins_out);
        wr(A_DIR, 32'h0F);
        ext <= xs();
        wr(A_DAT, {28'h0, ~d});
        rd(A_DAT, {28'h0, ext ^ p}, '1);
        chk_pin(d ^ p, pins_out);
        wr(A_DIR, 32'h00);
        rd(A_DAT, {28'h0, d}, '1);
        wr(A_DIR, 32'h0F);
        wr(A_IEN, 32'h0F);
        rd(A_EVT, 32'h00, 32'h00);
        wr(A_ICL, 32'h0F);
        rd(A_ICL, 32'h00, '1);
        // Edge events, read-to-clear and the interrupt mask
        repeat (3)
        begin
            t = xs() | 4'h1;
            ext <= ext ^ t;
            repeat (5) @(posedge clk_in);
            chk_pin(4'h1, {3'h0, irq});
            rd(A_EVT, {28'h0, t}, '1);
            rd(A_EVT, 32'h00, '1);
            rd(A_IST, {28'h0, t}, '1);
            wr(A_IEN, 32'h00);
            repeat (2) @(posedge clk_in);
            chk_pin(4'h0, {3'h0, irq});
            wr(A_IEN, 32'h0F);
            wr(A_ICL, 32'h0F);
            repeat (2) @(posedge clk_in);
            chk_pin(4'h0, {3'h0, irq});
        end
        // Enable low stalls a write; it must still land once enable returns
        fork
            wr(A_POL, {28'h0, ~p});
            begin
                ce <= 1'b0;
                repeat (4) @(posedge clk_in);
                ce <= 1'b1;
            end
        join
        p = ~p;
        host_rst_n <= 1'b0;
        repeat (2) @(posedge clk_in);
        host_rst_n <= 1'b1;
        rd(A_POL, {28'h0, p}, '1);
        // Pins idle high across the release: no edge may be flagged
        ext <= 4'hF;
        repeat (3) @(posedge clk_in);
        reset_in <= 1'b1;
        repeat (3) @(posedge clk_in);
        reset_in <= 1'b0;
        rd(A_DIR, 32'h0F, '1);
        rd(A_POL, 32'h00, '1);
        rd(A_EVT, 32'h00, '1);
        wr(A_DIR, 32'h00);
        rd(A_DAT, 32'h00, '1);
        give_verdict();
    end
endmodule
